// >>> rtl/control_word_check.sv
// decoding and checking of the three receive control words
`timescale 1ns/100ps
module control_word_check (
    input  wire logic [15:0] ctrl0_i,
    input  wire logic [15:0] ctrl1_i,
    input  wire logic [15:0] ctrl2_i,
    input  wire logic [15:0] dst_word_i,
    input  wire logic [15:0] dst_area_last_i,
    input  wire logic        indirect_i,
    input  wire logic [15:0] indirect_word_i,
    input  wire logic [15:0] dm_last_i,
    input  wire logic        link_present_i,
    output logic             fault_o,
    output logic             retry_o,
    output logic [15:0]      count_o,
    output logic [7:0]       node_o,
    output logic [7:0]       net_o,
    output logic             level0_o,
    output logic [7:0]       unit_port_o,
    output logic [7:0]       limit_steps_o,
    output logic             unlimited_o
);
    logic [3:0]  digit_bad;
    logic [16:0] last_written;
    logic        node_bad;
    logic        count_bad;
    logic        overflow;
    logic        indirect_bad;

    // one decimal digit check per nibble of the indirect pointer
    for (genvar d = 0; d < 4; d++)
    begin : g_bcd
        assign digit_bad[d] = indirect_word_i[4*d +: 4] > 4'h9;
    end

    assign retry_o  = ctrl1_i[netrecv_pkg::VARIANT_BIT];
    assign count_o  = ctrl0_i;
    assign net_o    = retry_o ? 8'h00 : {1'b0, ctrl1_i[6:0]};
    assign level0_o = !retry_o && ctrl1_i[netrecv_pkg::LEVEL_BIT];
    // source node and unit port code
    assign node_o      = ctrl2_i[7:0];
    assign unit_port_o = retry_o ? 8'h00 : ctrl2_i[15:8];

    // response limit; on a retry link zero means two seconds, all ones means none
    always_comb
    begin
        unlimited_o   = 1'b0;
        limit_steps_o = netrecv_pkg::ROUTED_LIMIT_STEPS;
        if (retry_o)
        begin
            unlimited_o   = ctrl1_i[7:0] == netrecv_pkg::LIMIT_CODE_NONE;
            limit_steps_o = (ctrl1_i[7:0] == netrecv_pkg::LIMIT_CODE_DFLT)
                          ? netrecv_pkg::DEFAULT_LIMIT_STEPS : ctrl1_i[7:0];
        end
    end

    assign node_bad  = retry_o ? (node_o > netrecv_pkg::MAX_NODE_RETRY)
                               : (node_o > netrecv_pkg::MAX_NODE_ROUTED);
    assign count_bad = retry_o ? (ctrl0_i > netrecv_pkg::MAX_COUNT_RETRY)
                               : (ctrl0_i > netrecv_pkg::MAX_COUNT_ROUTED);
    // block must end inside the destination area
    assign last_written = {1'b0, dst_word_i} + {1'b0, ctrl0_i} - 17'h0_0001;
    assign overflow     = (dst_word_i > dst_area_last_i)
                       || ((ctrl0_i != 16'h0000) && (last_written > {1'b0, dst_area_last_i}));
    // pointer must be decimal and inside the area
    assign indirect_bad = indirect_i && ((|digit_bad) || (indirect_word_i > dm_last_i));

    // no link unit is a fault too
    assign fault_o = node_bad || count_bad || overflow || indirect_bad || !link_present_i;
endmodule

// >>> rtl/netrecv_pkg.sv
// constants and types shared by the network receive control block
package netrecv_pkg;

    // clock rate and time bases
    localparam int unsigned CLK_MHZ             = 200;
    localparam int unsigned STEP_MS             = 100;   // response limit step, 0.1 s
    localparam int unsigned STEP_CYCLES         = STEP_MS * 1000 * CLK_MHZ;
    localparam int unsigned EXCHANGE_TIMEOUT_MS = 1000;  // routed link time-out
    localparam int unsigned DEFAULT_LIMIT_MS    = 2000;  // limit code zero on retry link
    localparam logic [7:0]  ROUTED_LIMIT_STEPS  = 8'(EXCHANGE_TIMEOUT_MS / STEP_MS);
    localparam logic [7:0]  DEFAULT_LIMIT_STEPS = 8'(DEFAULT_LIMIT_MS / STEP_MS);

    // control word field positions
    localparam int unsigned VARIANT_BIT = 15;  // second word: 1 retry link, 0 routed
    localparam int unsigned LEVEL_BIT   = 14;  // second word, routed: 1 level 0

    // control word ranges
    localparam logic [15:0] MAX_COUNT_ROUTED = 16'h03E8;
    localparam logic [15:0] MAX_COUNT_RETRY  = 16'h0100;
    localparam logic [7:0]  MAX_NODE_ROUTED  = 8'h7E;
    localparam logic [7:0]  MAX_NODE_RETRY   = 8'h3E;
    localparam logic [7:0]  LIMIT_CODE_DFLT  = 8'h00;
    localparam logic [7:0]  LIMIT_CODE_NONE  = 8'hFF;
    localparam logic [7:0]  REMOTE_PORT      = 8'h00;  // remote source port, routed and retry link
    localparam logic [15:0] DM_LAST_DEFAULT  = 16'h1999;

    // values after reset
    localparam logic        ENABLE_RST = 1'b1;
    localparam logic        ERROR_RST  = 1'b0;
    localparam logic        FAULT_RST  = 1'b0;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ISSUE,
        ST_RECEIVE,
        ST_FINISH,
        ST_RELEASE
    } state_t;

endpackage

// >>> rtl/network_receive_control.sv
// receive request interpreter: decode, fetch remote block, keep flags
`timescale 1ns/100ps
module network_receive_control #(
    parameter int unsigned STEP_CYCLES = netrecv_pkg::STEP_CYCLES
) (
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    // program side
    input  wire logic        exec_cond_i,
    input  wire logic        network_receive_request_i,
    input  wire logic [15:0] ctrl0_i,
    input  wire logic [15:0] ctrl1_i,
    input  wire logic [15:0] ctrl2_i,
    input  wire logic [15:0] src_word_i,
    input  wire logic [15:0] dst_word_i,
    input  wire logic [15:0] dst_area_last_i,
    input  wire logic        indirect_i,
    input  wire logic [15:0] indirect_word_i,
    input  wire logic [15:0] dm_last_i,
    input  wire logic        end_of_program_i,
    input  wire logic        service_period_i,
    input  wire logic        link_present_i,
    output logic             completion_enable_o,
    output logic             transfer_error_o,
    output logic             instruction_fault_flag_o,
    // link unit side
    output logic             link_cmd_valid_o,
    input  wire logic        link_cmd_ready_i,
    output logic             link_retry_o,
    output logic [7:0]       link_node_o,
    output logic [7:0]       link_net_o,
    output logic             link_level0_o,
    output logic [7:0]       link_unit_port_o,
    output logic [7:0]       link_remote_port_o,
    output logic [15:0]      link_src_word_o,
    output logic [15:0]      link_count_o,
    input  wire logic        link_rsp_valid_i,
    input  wire logic [15:0] link_rsp_data_i,
    input  wire logic        link_rsp_last_i,
    input  wire logic        link_rsp_error_i,
    output logic             link_ack_o,
    // local memory write port
    output logic             mem_we_o,
    output logic [15:0]      mem_addr_o,
    output logic [15:0]      mem_wdata_o
);
    typedef struct packed {
        netrecv_pkg::state_t state;
        logic                present_meta;
        logic                present_sync;
        logic                enable;
        logic                error;
        logic                fault;
        logic                result_bad;
        logic                retry;
        logic [7:0]          node;
        logic [7:0]          net;
        logic                level0;
        logic [7:0]          unit_port;
        logic [7:0]          remote_port;
        logic [15:0]         src_word;
        logic [15:0]         count;
        logic [15:0]         left;
        logic [15:0]         addr;
        logic                we;
        logic [15:0]         wdata;
        logic                ack;
    } ctl_t;

    ctl_t s_reg;
    ctl_t s_next;

    logic        chk_fault;
    logic        chk_retry;
    logic [15:0] chk_count;
    logic [7:0]  chk_node;
    logic [7:0]  chk_net;
    logic        chk_level0;
    logic [7:0]  chk_unit_port;
    logic [7:0]  chk_limit_steps;
    logic        chk_unlimited;
    logic        accept;
    logic        timer_start;
    logic        timer_stop;
    logic        timed_out;

    initial
    begin
        if (STEP_CYCLES < 1)
            $error("network_receive_control: STEP_CYCLES must be at least one");
    end

    control_word_check u_check (
        .ctrl0_i         (ctrl0_i),
        .ctrl1_i         (ctrl1_i),
        .ctrl2_i         (ctrl2_i),
        .dst_word_i      (dst_word_i),
        .dst_area_last_i (dst_area_last_i),
        .indirect_i      (indirect_i),
        .indirect_word_i (indirect_word_i),
        .dm_last_i       (dm_last_i),
        .link_present_i  (s_reg.present_sync),
        .fault_o         (chk_fault),
        .retry_o         (chk_retry),
        .count_o         (chk_count),
        .node_o          (chk_node),
        .net_o           (chk_net),
        .level0_o        (chk_level0),
        .unit_port_o     (chk_unit_port),
        .limit_steps_o   (chk_limit_steps),
        .unlimited_o     (chk_unlimited)
    );

    // exchange limit runs from command issue to last response
    response_timer #(
        .TICK_CYCLES (STEP_CYCLES)
    ) u_timer (
        .clk_i         (clk_i),
        .resetn_i      (resetn_i),
        .start_i       (timer_start),
        .limit_steps_i (chk_limit_steps),
        .unlimited_i   (chk_unlimited),
        .stop_i        (timer_stop),
        .expired_o     (timed_out)
    );

    // a request counts only with the condition on
    // and only while the enable flag is set
    assign accept      = network_receive_request_i && exec_cond_i
                      && (s_reg.state == netrecv_pkg::ST_IDLE) && s_reg.enable;
    assign timer_start = accept && !chk_fault;
    assign timer_stop  = (s_reg.state == netrecv_pkg::ST_FINISH);

    // next state of the whole controller
    always_comb
    begin
        s_next              = s_reg;
        s_next.present_meta = link_present_i;
        s_next.present_sync = s_reg.present_meta;  // unit presence is a strap pin
        s_next.we           = 1'b0;
        s_next.ack          = 1'b0;
        case (s_reg.state)
            netrecv_pkg::ST_IDLE:
            begin
                if (accept)
                begin
                    // parameter faults abort before any transfer
                    s_next.fault = chk_fault;
                    if (!chk_fault)
                    begin
                        // old error status ends as the transfer starts
                        s_next.error       = 1'b0;
                        // enable drops for the whole exchange
                        s_next.enable      = 1'b0;
                        s_next.result_bad  = 1'b0;
                        s_next.retry       = chk_retry;
                        s_next.node        = chk_node;
                        s_next.net         = chk_net;
                        s_next.level0      = chk_level0;
                        s_next.unit_port   = chk_unit_port;
                        s_next.remote_port = netrecv_pkg::REMOTE_PORT;
                        s_next.src_word    = src_word_i;
                        s_next.count       = chk_count;
                        s_next.left        = chk_count;
                        s_next.addr        = dst_word_i;
                        s_next.state       = netrecv_pkg::ST_ISSUE;
                    end
                end
            end
            netrecv_pkg::ST_ISSUE:
            begin
                // a unit that never takes the command also times out
                if (timed_out)
                begin
                    s_next.result_bad = 1'b1;
                    s_next.state      = netrecv_pkg::ST_FINISH;
                end
                else if (link_cmd_ready_i)
                    s_next.state = netrecv_pkg::ST_RECEIVE;
            end
            netrecv_pkg::ST_RECEIVE:
            begin
                if (timed_out)
                begin
                    s_next.result_bad = 1'b1;
                    s_next.state      = netrecv_pkg::ST_FINISH;
                end
                else if (link_rsp_valid_i)
                begin
                    // write each word in order; surplus never lands
                    if (!link_rsp_error_i && (s_reg.left != 16'h0000))
                    begin
                        s_next.we    = 1'b1;
                        s_next.wdata = link_rsp_data_i;
                        s_next.left  = s_reg.left - 16'h0001;
                    end
                    if (link_rsp_error_i || (s_reg.left == 16'h0000))
                        s_next.result_bad = 1'b1;  // data error
                    // done on the last word, acknowledged in the next cycle
                    if (link_rsp_last_i)
                    begin
                        s_next.ack = 1'b1;
                        if (s_reg.left != 16'h0001 && s_reg.left != 16'h0000)
                            s_next.result_bad = 1'b1;  // short block
                        s_next.state = netrecv_pkg::ST_FINISH;
                    end
                end
            end
            netrecv_pkg::ST_FINISH:
            begin
                // result posted in the link service period
                if (service_period_i)
                begin
                    // error set on failure, cleared on success
                    s_next.error = s_reg.result_bad;
                    s_next.state = netrecv_pkg::ST_RELEASE;
                end
            end
            netrecv_pkg::ST_RELEASE:
            begin
                // enable returns at the next end of program
                if (end_of_program_i)
                begin
                    s_next.enable = 1'b1;
                    s_next.state  = netrecv_pkg::ST_IDLE;
                end
            end
            default:
                s_next.state = netrecv_pkg::ST_IDLE;
        endcase
        // address steps after each written word
        if (s_reg.we)
            s_next.addr = s_reg.addr + 16'h0001;
    end

    // single register stage for all control state
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            s_reg        <= '0;
            s_reg.state  <= netrecv_pkg::ST_IDLE;
            s_reg.enable <= netrecv_pkg::ENABLE_RST;
            s_reg.error  <= netrecv_pkg::ERROR_RST;
            s_reg.fault  <= netrecv_pkg::FAULT_RST;
        end
        else
            s_reg <= s_next;
    end

    // flag and link outputs straight from the state register
    assign completion_enable_o      = s_reg.enable;
    assign transfer_error_o         = s_reg.error;
    assign instruction_fault_flag_o = s_reg.fault;
    assign link_cmd_valid_o         = (s_reg.state == netrecv_pkg::ST_ISSUE);
    assign link_retry_o             = s_reg.retry;
    assign link_node_o              = s_reg.node;
    assign link_net_o               = s_reg.net;
    assign link_level0_o            = s_reg.level0;
    assign link_unit_port_o         = s_reg.unit_port;
    assign link_remote_port_o       = s_reg.remote_port;
    assign link_src_word_o          = s_reg.src_word;
    assign link_count_o             = s_reg.count;
    assign link_ack_o               = s_reg.ack;

    // memory port; address is the word being written this cycle
    assign mem_we_o    = s_reg.we;
    assign mem_addr_o  = s_reg.addr;
    assign mem_wdata_o = s_reg.wdata;
endmodule

// >>> rtl/response_timer.sv
// response time limit counter in 0.1 s steps
`timescale 1ns/100ps
module response_timer #(
    parameter int unsigned TICK_CYCLES = netrecv_pkg::STEP_CYCLES
) (
    input  wire logic       clk_i,
    input  wire logic       resetn_i,
    input  wire logic       start_i,
    input  wire logic [7:0] limit_steps_i,
    input  wire logic       unlimited_i,
    input  wire logic       stop_i,
    output logic            expired_o
);
    typedef struct packed {
        logic [25:0] cyc;
        logic [7:0]  steps;
        logic        running;
        logic        expired;
    } timer_t;

    timer_t t_reg;
    timer_t t_next;

    // the cycle counter within a step is 26 bits wide
    initial
    begin
        if (TICK_CYCLES < 1 || TICK_CYCLES > 67108864)
            $error("response_timer: TICK_CYCLES out of range");
    end

    // load on start, count down whole steps, stop clears
    always_comb
    begin
        t_next = t_reg;
        if (stop_i)
        begin
            t_next.running = 1'b0;
            t_next.expired = 1'b0;
        end
        else if (start_i)
        begin
            t_next.running = !unlimited_i && (limit_steps_i != 8'h00);
            t_next.expired = 1'b0;
            t_next.steps   = limit_steps_i;
            t_next.cyc     = '0;
        end
        else if (t_reg.running)
        begin
            if (t_reg.cyc == 26'(TICK_CYCLES - 1))
            begin
                t_next.cyc = '0;
                if (t_reg.steps <= 8'h01)
                begin
                    t_next.expired = 1'b1;
                    t_next.running = 1'b0;
                end
                else
                    t_next.steps = t_reg.steps - 8'h01;
            end
            else
                t_next.cyc = t_reg.cyc + 26'h0000_001;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            t_reg <= '0;
        else
            t_reg <= t_next;
    end

    assign expired_o = t_reg.expired;
endmodule

// >>> tb/network_receive_control_monitor.sv
// assertion checker for the network receive control block
`timescale 1ns/100ps
module network_receive_control_monitor (
    input wire logic       clk_i,
    input wire logic       resetn_i,
    input wire logic       exec_cond_i,
    input wire logic       network_receive_request_i,
    input wire logic [15:0] ctrl1_i,
    input wire logic [15:0] ctrl2_i,
    input wire logic       end_of_program_i,
    input wire logic       service_period_i,
    input wire logic       link_present_i,
    input wire logic       completion_enable_o,
    input wire logic       transfer_error_o,
    input wire logic       instruction_fault_flag_o,
    input wire logic       link_cmd_valid_o,
    input wire logic [7:0] link_remote_port_o,
    input wire logic       link_rsp_valid_i,
    input wire logic       link_rsp_last_i,
    input wire logic       link_ack_o,
    input wire logic       mem_we_o
);
    // request accepted at this edge
    logic take;
    assign take = exec_cond_i && network_receive_request_i && completion_enable_o;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);

    property p_cmd_cause;
        $rose(link_cmd_valid_o) |-> $past(exec_cond_i) && $past(network_receive_request_i);
    endproperty
    a_cmd_cause: assert property (p_cmd_cause) else $error("command without request");
    property p_busy_flag;
        link_cmd_valid_o |-> !completion_enable_o ##1 !completion_enable_o;
    endproperty
    a_busy_flag: assert property (p_busy_flag) else $error("enable high in exchange");
    property p_enable_end;
        $rose(completion_enable_o) |-> $past(end_of_program_i);
    endproperty
    a_enable_end: assert property (p_enable_end) else $error("enable rose off end point");
    property p_ack_last;
        link_ack_o |-> $past(link_rsp_valid_i) && $past(link_rsp_last_i);
    endproperty
    a_ack_last: assert property (p_ack_last) else $error("ack without last word");
    property p_write_cause;
        mem_we_o |-> $past(link_rsp_valid_i) && !completion_enable_o;
    endproperty
    a_write_cause: assert property (p_write_cause) else $error("write without word");
    property p_port_zero;
        link_remote_port_o == netrecv_pkg::REMOTE_PORT;
    endproperty
    a_port_zero: assert property (p_port_zero) else $error("remote port not zero");
    property p_node_fault;
        take && (ctrl1_i[15] ? ctrl2_i[7:0] > netrecv_pkg::MAX_NODE_RETRY
                             : ctrl2_i[7:0] > netrecv_pkg::MAX_NODE_ROUTED)
        |=> instruction_fault_flag_o && completion_enable_o && !link_cmd_valid_o;
    endproperty
    a_node_fault: assert property (p_node_fault) else $error("node range not refused");
    property p_link_fault;
        take && !link_present_i && !$past(link_present_i) && !$past(link_present_i, 2)
        |=> instruction_fault_flag_o && !link_cmd_valid_o;
    endproperty
    a_link_fault: assert property (p_link_fault) else $error("missing link not refused");
    property p_error_post;
        $rose(transfer_error_o) |-> $past(service_period_i) && !completion_enable_o;
    endproperty
    a_error_post: assert property (p_error_post) else $error("error set off service");
endmodule
bind network_receive_control network_receive_control_monitor u_mon (.*);

// >>> tb/network_receive_control_tb_top.sv
// testbench for the network receive control block
`timescale 1ns/100ps
module network_receive_control_tb_top;
    logic        clk_i, resetn_i, exec_cond_i, network_receive_request_i, indirect_i;
    logic        end_of_program_i, service_period_i, link_present_i, link_cmd_ready_i;
    logic        link_rsp_valid_i, link_rsp_last_i, link_rsp_error_i, link_ack_o, mem_we_o;
    logic        completion_enable_o, transfer_error_o, instruction_fault_flag_o;
    logic        link_cmd_valid_o, link_retry_o, link_level0_o;
    logic [15:0] ctrl0_i, ctrl1_i, ctrl2_i, src_word_i, dst_word_i, dst_area_last_i;
    logic [15:0] indirect_word_i, dm_last_i, link_rsp_data_i, link_src_word_o;
    logic [15:0] link_count_o, mem_addr_o, mem_wdata_o;
    logic [7:0]  link_node_o, link_net_o, link_unit_port_o, link_remote_port_o, cyc;
    logic [1:0]  mode;
    int          miscompares, num_checks, wr;

    network_receive_control #(.STEP_CYCLES(10)) DUT (.clk_i, .resetn_i, .exec_cond_i,
        .network_receive_request_i, .ctrl0_i, .ctrl1_i, .ctrl2_i, .src_word_i, .dst_word_i,
        .dst_area_last_i, .indirect_i, .indirect_word_i, .dm_last_i, .end_of_program_i,
        .service_period_i, .link_present_i, .completion_enable_o, .transfer_error_o,
        .instruction_fault_flag_o, .link_cmd_valid_o, .link_cmd_ready_i, .link_retry_o,
        .link_node_o, .link_net_o, .link_level0_o, .link_unit_port_o, .link_remote_port_o,
        .link_src_word_o, .link_count_o, .link_rsp_valid_i, .link_rsp_data_i,
        .link_rsp_last_i, .link_rsp_error_i, .link_ack_o, .mem_we_o, .mem_addr_o,
        .mem_wdata_o);
    remote_node_model u_node (.clk_i(clk_i), .cmd_valid_i(link_cmd_valid_o),
        .count_i(link_count_o), .src_i(link_src_word_o), .mode_i(mode),
        .cmd_ready_o(link_cmd_ready_i), .rsp_valid_o(link_rsp_valid_i),
        .rsp_data_o(link_rsp_data_i), .rsp_last_o(link_rsp_last_i),
        .rsp_error_o(link_rsp_error_i));

    // 200 MHz clock
    initial
    begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    task chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // bounded wait for the enable flag
    task wait_en();
        for (int n = 0; n < 2000 && (n == 0 || completion_enable_o !== 1'b1); n++)
        begin
            @(posedge clk_i);
            #1;
        end
        chk(completion_enable_o, 1'b1);
    endtask

    // one receive request; f expects a fault, e an error
    task xfer(input logic [15:0] c0, c1, c2, dst, input logic [1:0] m, input logic f, e);
        wait_en();
        mode = m;
        {ctrl0_i, ctrl1_i, ctrl2_i, dst_word_i} = {c0, c1, c2, dst};
        wr = 0;
        network_receive_request_i = 1'b1;
        @(posedge clk_i);
        #1;
        network_receive_request_i = !f;
        chk(instruction_fault_flag_o, f);
        chk(completion_enable_o, f);
        if (!f)
        begin
            chk(transfer_error_o, 1'b0);
            // request held while busy is ignored
            ctrl2_i = c2 ^ 16'h0001;
            @(posedge clk_i);
            #1;
            network_receive_request_i = 1'b0;
            chk(link_node_o, c2[7:0]);
            chk(link_retry_o, c1[15]);
            chk(link_count_o, c0);
            if (!c1[15])
            begin
                chk(link_net_o, c1[7:0]);
                chk(link_level0_o, c1[14]);
                chk(link_unit_port_o, c2[15:8]);
            end
            wait_en();
            chk(transfer_error_o, e);
            if (!e) chk(16'(wr), c0);
        end
    endtask

    // every written word lands in order, sampled mid-cycle
    always @(negedge clk_i)
        if (mem_we_o === 1'b1)
        begin
            chk(mem_addr_o, dst_word_i + 16'(wr));
            chk(mem_wdata_o, (link_src_word_o + 16'(wr)) ^ 16'hC3C3);
            wr++;
        end

    // scan cycle: service period then end point, off the edge
    always @(posedge clk_i)
    begin
        #1;
        cyc = cyc + 8'h01;
        service_period_i = (cyc[3:1] == 3'h1);
        end_of_program_i = (cyc[3:0] == 4'hA);
    end

    // watchdog well past the expected run
    initial
    begin
        #200000;
        miscompares++;
        report_and_stop();
    end

    initial
    begin
        {resetn_i, network_receive_request_i, indirect_i, cyc, mode} = 13'h0000;
        {exec_cond_i, link_present_i, end_of_program_i, service_period_i} = 4'hC;
        {ctrl0_i, ctrl1_i, ctrl2_i, dst_word_i} = 64'h0;
        {src_word_i, dst_area_last_i} = {16'h0120, 16'h07FF};
        {indirect_word_i, dm_last_i} = {16'h0000, netrecv_pkg::DM_LAST_DEFAULT};
        repeat (20) @(posedge clk_i);
        #1;
        resetn_i = 1'b1;
        chk(completion_enable_o, netrecv_pkg::ENABLE_RST);
        chk(transfer_error_o, netrecv_pkg::ERROR_RST);
        repeat (3) @(posedge clk_i);
        #1;
        // condition off: nothing starts
        {exec_cond_i, network_receive_request_i} = 2'b01;
        @(posedge clk_i);
        #1;
        {exec_cond_i, network_receive_request_i} = 2'b10;
        chk(link_cmd_valid_o, 1'b0);
        chk(completion_enable_o, 1'b1);
        // routed, level 0, reserved bits zero, ends on area end
        xfer(16'h0003, 16'h407F, 16'h017E, 16'h07FD, 2'd0, 1'b0, 1'b0);
        xfer(16'h0002, 16'h0000, 16'h0005, 16'h0010, 2'd1, 1'b0, 1'b1);
        // no limit, slow node, full retry count
        xfer(16'h0100, 16'h80FF, 16'h003E, 16'h0400, 2'd3, 1'b0, 1'b0);
        // one step limit against a mute node
        xfer(16'h0004, 16'h8001, 16'h0001, 16'h0020, 2'd2, 1'b0, 1'b1);
        xfer(16'h0001, 16'h0000, 16'h007F, 16'h0010, 2'd0, 1'b1, 1'b0);
        xfer(16'h0001, 16'h8000, 16'h003F, 16'h0010, 2'd0, 1'b1, 1'b0);
        xfer(16'h0003, 16'h0000, 16'h0001, 16'h07FE, 2'd0, 1'b1, 1'b0);
        {indirect_i, indirect_word_i} = {1'b1, 16'h00A0};
        xfer(16'h0001, 16'h0000, 16'h0001, 16'h0010, 2'd0, 1'b1, 1'b0);
        indirect_i = 1'b0;
        link_present_i = 1'b0;
        repeat (4) @(posedge clk_i);
        #1;
        xfer(16'h0001, 16'h0000, 16'h0001, 16'h0010, 2'd0, 1'b1, 1'b0);
        report_and_stop();
    end
endmodule

// >>> tb/remote_node_model.sv
// remote node model answering receive commands on the link
`timescale 1ns/100ps
module remote_node_model (
    input  wire logic        clk_i,
    input  wire logic        cmd_valid_i,
    input  wire logic [15:0] count_i,
    input  wire logic [15:0] src_i,
    input  wire logic [1:0]  mode_i,
    output logic             cmd_ready_o,
    output logic             rsp_valid_o,
    output logic [15:0]      rsp_data_o,
    output logic             rsp_last_o,
    output logic             rsp_error_o
);
    int n;
    // mode 0 prompt, 1 bad last word, 2 mute, 3 slow
    initial
    begin
        {cmd_ready_o, rsp_valid_o, rsp_last_o, rsp_error_o} = 4'h0;
        rsp_data_o = 16'h0000;
        forever
        begin
            @(posedge clk_i);
            #1;
            if (cmd_valid_i === 1'b1)
            begin
                #(mode_i == 2'd3 ? 20 : 0);
                cmd_ready_o = 1'b1;
                n = int'(count_i);
                @(posedge clk_i);
                #1;
                cmd_ready_o = 1'b0;
                for (int k = 0; k < n && mode_i != 2'd2; k++)
                begin
                    rsp_valid_o = 1'b1;
                    rsp_data_o  = (src_i + 16'(k)) ^ 16'hC3C3;
                    rsp_last_o  = (k == n - 1);
                    rsp_error_o = (mode_i == 2'd1) && (k == n - 1);
                    @(posedge clk_i);
                    #1;
                end
                {rsp_valid_o, rsp_last_o, rsp_error_o} = 3'h0;
                // released lines show the held word inverted, so a mute reply brings back the previous word
                rsp_data_o = ~rsp_data_o;
            end
        end
    end
endmodule
